// File: src/ulf_line_format.sv
// line-format control register with APB slave and decoded framing outputs
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ulf_line_format (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_serial_in,
   output logic serial_tx_line,
   output logic rx_queue_flush,
   output ulf_pkg::ulf_format_t format
);
   logic [7:0] line_format_control;
   logic hit;
   logic setup;
   logic write_take;
   logic [1:0] width_field;
   logic [3:0] fmt_data_bits;
   ulf_pkg::ulf_stop_t fmt_stop;
   logic fmt_parity_on;
   logic fmt_parity_even;
   logic fmt_parity_forced;
   logic fmt_force_value;
   logic fmt_break;
   logic fmt_queue_on;

   // width decode feeds the data count
   function automatic logic [3:0] ulf_data_bits(
      input logic [1:0] sel
   );
      return ulf_pkg::ULF_DATA_BITS_MIN + {2'h0, sel};
   endfunction

   function automatic ulf_pkg::ulf_stop_t ulf_stop_decode(
      input logic stop_sel,
      input logic [1:0] sel
   );
      ulf_pkg::ulf_stop_t mode;
      mode = ulf_pkg::ULF_STOP_ONE;
      if (stop_sel) begin
         if (sel == ulf_pkg::ULF_WIDTH_5) begin
            mode = ulf_pkg::ULF_STOP_ONE_HALF;
         end else begin
            mode = ulf_pkg::ULF_STOP_TWO;
         end
      end
      return mode;
   endfunction

   function automatic logic [31:0] ulf_read_word(
      input logic [7:0] value
   );
      return {24'h000000, value};
   endfunction

   // one field bit of the stored byte
   function automatic logic ulf_field_bit(
      input logic [7:0] value,
      input int pos
   );
      return value[pos];
   endfunction

   assign hit = (paddr == ulf_pkg::ULF_LINE_FORMAT_ADDR);
   // zero-wait-state slave: answer registered at the end of the setup phase
   assign setup = psel && !penable;
   // a write lands only at the edge where pready is seen high
   assign write_take = psel && penable && pready && pwrite && hit;
   assign width_field = line_format_control[ulf_pkg::ULF_WIDTH_LSB +: 2];

   // only the low byte is stored; upper write bits are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_format_control <= ulf_pkg::ULF_LINE_FORMAT_RESET;
      end else if (write_take) begin
         line_format_control <= pwdata[7:0];
      end
   end

   // pready is a one-cycle pulse, never held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup && !hit) begin
         pslverr <= 1'b1;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // unmapped reads return zero with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite && hit) begin
         prdata <= ulf_read_word(line_format_control);
      end else begin
         prdata <= 32'h00000000;
      end
   end

   // decoded fields registered so every output leaves a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_data_bits <= '0;
      end else begin
         fmt_data_bits <= ulf_data_bits(width_field);
      end
   end

   // 1.5 stops only for five-bit characters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_stop <= ulf_pkg::ULF_STOP_ONE;
      end else begin
         fmt_stop <= ulf_stop_decode(ulf_field_bit(line_format_control, ulf_pkg::ULF_STOP_BIT),
            width_field);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_parity_on <= 1'b0;
      end else begin
         fmt_parity_on <= ulf_field_bit(line_format_control, ulf_pkg::ULF_PAR_ON_BIT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_parity_even <= 1'b0;
      end else begin
         fmt_parity_even <= ulf_field_bit(line_format_control, ulf_pkg::ULF_PAR_EVEN_BIT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_parity_forced <= 1'b0;
      end else begin
         fmt_parity_forced <= ulf_field_bit(line_format_control, ulf_pkg::ULF_PAR_FORCE_BIT);
      end
   end

   // forced value is the inverse of even-select; only the 0 case is defined
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_force_value <= 1'b0;
      end else begin
         fmt_force_value <= !ulf_field_bit(line_format_control, ulf_pkg::ULF_PAR_EVEN_BIT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_break <= 1'b0;
      end else begin
         fmt_break <= ulf_field_bit(line_format_control, ulf_pkg::ULF_BREAK_BIT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_queue_on <= 1'b0;
      end else begin
         fmt_queue_on <= ulf_field_bit(line_format_control, ulf_pkg::ULF_QUEUE_BIT);
      end
   end

   // pure wiring of flops, field order as the carrier declares it
   assign format = {
      fmt_data_bits,
      fmt_stop,
      fmt_parity_on,
      fmt_parity_even,
      fmt_parity_forced,
      fmt_force_value,
      fmt_break,
      fmt_queue_on
   };

   // flush held while the queue bit is 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_queue_flush <= 1'b1;
      end else begin
         rx_queue_flush <= !ulf_field_bit(line_format_control, ulf_pkg::ULF_QUEUE_BIT);
      end
   end

   // transmitter drives its frame from the same-clock shifter; break overrides
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_tx_line <= 1'b1;
      end else begin
         serial_tx_line <= tx_serial_in
            && !ulf_field_bit(line_format_control, ulf_pkg::ULF_BREAK_BIT);
      end
   end
endmodule // ulf_line_format

// File: src/ulf_pkg.sv
// package: register map, field positions and carrier types for the line-format block
package ulf_pkg;
   localparam logic [15:0] ULF_LINE_FORMAT_ADDR = 16'hFFA2;
   localparam logic [7:0] ULF_LINE_FORMAT_RESET = 8'h00;
   localparam int ULF_WIDTH_LSB = 0;
   localparam int ULF_STOP_BIT = 2;
   localparam int ULF_PAR_ON_BIT = 3;
   localparam int ULF_PAR_EVEN_BIT = 4;
   localparam int ULF_PAR_FORCE_BIT = 5;
   localparam int ULF_BREAK_BIT = 6;
   localparam int ULF_QUEUE_BIT = 7;
   localparam logic [1:0] ULF_WIDTH_5 = 2'h0;
   localparam logic [3:0] ULF_DATA_BITS_MIN = 4'h5;

   typedef enum logic [1:0] {
      ULF_STOP_ONE,
      ULF_STOP_ONE_HALF,
      ULF_STOP_TWO
   } ulf_stop_t;

   typedef struct packed {
      logic [3:0] data_bits;
      ulf_stop_t stop_mode;
      logic parity_on;
      logic parity_even;
      logic parity_forced;
      logic parity_force_value;
      logic line_break_force;
      logic rx_queue_on;
   } ulf_format_t;
endpackage

// File: testbench/ulf_line_format_asserts.sv
// checker: line-format decode and readback
`timescale 1ns/1ps
module ulf_line_format_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_serial_in,
   input wire logic serial_tx_line,
   input wire logic rx_queue_flush,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire ulf_pkg::ulf_format_t format
);
   logic [7:0] sh, shp;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_hit; pready && psel && paddr == 16'hFFA2; endsequence
   sequence s_break_on; presetn && sh[6]; endsequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh <= 8'h00;
         shp <= 8'h00;
      end else begin
         shp <= sh;
         if (pready && psel && penable && pwrite && paddr == 16'hFFA2) sh <= pwdata[7:0];
      end
   end
   // presetn in the antecedent keeps the release edge, where outputs still show reset, out
   a_width_decode: assert property (presetn |=> format.data_bits == 4'h5 + shp[1:0])
      else $error("width wrong");
   a_stop_count: assert property (presetn |=> format.stop_mode == (!shp[2] ? ulf_pkg::ULF_STOP_ONE :
      shp[1:0] == 2'h0 ? ulf_pkg::ULF_STOP_ONE_HALF : ulf_pkg::ULF_STOP_TWO))
      else $error("stop mode wrong");
   a_parity_enable: assert property (presetn |=> format.parity_on == shp[3])
      else $error("parity on");
   a_parity_sense: assert property (presetn |=> format.parity_even == shp[4])
      else $error("sense");
   a_forced_value: assert property (presetn |=> format.parity_forced == shp[5] &&
      (!shp[5] || format.parity_force_value == !shp[4])) else $error("forced parity");
   a_break_low: assert property (presetn && !sh[6] |=> serial_tx_line == $past(tx_serial_in))
      else $error("line wrong");
   a_break_forced: assert property (s_break_on |=> !serial_tx_line)
      else $error("break not low");
   a_queue_flush: assert property (presetn |=> rx_queue_flush == !shp[7])
      else $error("flush wrong");
   a_error_flag: assert property (pready && psel |-> pslverr == (paddr != 16'hFFA2))
      else $error("error flag wrong");
   a_read_back: assert property (s_hit and !pwrite |-> prdata == {24'h0, sh})
      else $error("readback wrong");
endmodule // ulf_line_format_asserts
bind ulf_line_format ulf_line_format_asserts i_chk (.*);

// File: testbench/ulf_peer.sv
// remote serial peer: notes a low line
`timescale 1ns/1ps
module ulf_peer (
   input wire logic pclk,
   input wire logic line,
   output logic low_seen
);
   always_ff @(posedge pclk) low_seen <= !line;
endmodule // ulf_peer

// File: testbench/uart_line_format_control_test.sv
// bench: random format writes, readback, break and unmapped access
`timescale 1ns/1ps
module uart_line_format_control_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_serial_in = 1;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0, prdata, r, lf = 32'h1C9C;
   logic pready, pslverr, serial_tx_line, rx_queue_flush, low_seen, er;
   ulf_pkg::ulf_format_t format;
   int failures = 0, samples_checked = 0;
   ulf_line_format i_ulf_line_format (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .tx_serial_in(tx_serial_in),
      .serial_tx_line(serial_tx_line),
      .rx_queue_flush(rx_queue_flush),
      .format(format)
   );
   ulf_peer i_ulf_peer (.pclk(pclk), .line(serial_tx_line), .low_seen(low_seen));
   initial forever #2.5 pclk = ~pclk;
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic xfer(logic w, logic [15:0] a, logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (e !== g) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task summarize;
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      xfer(0, 16'hFFA2, 0);
      chk("reset", 32'h0, r);
      chk("mapped error", 32'h0, {31'h0, er});
      for (int i = 0; i < 20; i++) begin
         lf = nx(lf);
         tx_serial_in <= lf[9];
         xfer(1, 16'hFFA2, (i == 0) ? 32'h24 : lf); // corner: five bits with stop set
         xfer(0, 16'hFFA2, 0);
         chk("readback", {24'h0, (i == 0) ? 8'h24 : lf[7:0]}, r);
         if (i > 0) chk("flush", {31'h0, !lf[7]}, {31'h0, rx_queue_flush});
      end
      tx_serial_in <= 1'b1;
      xfer(1, 16'hFFA2, 32'h40);
      repeat (3) @(posedge pclk);
      chk("break", 32'h1, {31'h0, low_seen});
      xfer(0, 16'hFFA0, 0);
      chk("unmapped", 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, er});
      summarize;
   end
   initial begin
      #20000;
      failures++;
      summarize;
   end
endmodule // uart_line_format_control_test
